// file: inc/dtc_pkg.sv
package dtc_pkg;
    localparam logic [7:0] DTC_ADDR_CTRL   = 8'h88;
    localparam logic [7:0] DTC_ADDR_MODE   = 8'h89;
    localparam logic [7:0] DTC_ADDR_LOW0   = 8'h8A;
    localparam logic [7:0] DTC_ADDR_LOW1   = 8'h8B;
    localparam logic [7:0] DTC_ADDR_HIGH0  = 8'h8C;
    localparam logic [7:0] DTC_ADDR_HIGH1  = 8'h8D;
    localparam logic [7:0] DTC_CTRL_RESET  = 8'h00;
    localparam logic [7:0] DTC_MODE_RESET  = 8'h00;
    localparam logic [7:0] DTC_COUNT_RESET = 8'h00;
    // Control register bit positions
    localparam int DTC_CTRL_OVF1 = 7;
    localparam int DTC_CTRL_RUN1 = 6;
    localparam int DTC_CTRL_OVF0 = 5;
    localparam int DTC_CTRL_RUN0 = 4;
    // Mode register nibble layout (channel 1 adds 4)
    localparam int DTC_MODE_GATE  = 3;
    localparam int DTC_MODE_SRC   = 2;
    localparam int DTC_MODE_HI    = 1;
    localparam int DTC_MODE_LO    = 0;
    localparam int DTC_CH1_SHIFT  = 4;
    // Timer source divides the peripheral clock by this
    localparam int DTC_TIMER_DIV  = 6;
    localparam logic [2:0] DTC_DIV_LAST = 3'(DTC_TIMER_DIV - 1);
    localparam logic [4:0] DTC_PRESCALE_MAX = 5'h1F;
    typedef enum logic [1:0] {
        DTC_MODE_13BIT,
        DTC_MODE_16BIT,
        DTC_MODE_RELOAD,
        DTC_MODE_SPLIT
    } dtc_mode_e;
endpackage

// file: src/dtc_top.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
module dtc_top
    import dtc_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       arst_n_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic       count_input_ch0_in,
    input  wire logic       count_input_ch1_in,
    input  wire logic       ext_gate_pin_ch0_in,
    input  wire logic       ext_gate_pin_ch1_in,
    input  wire logic       isr_enter_ch0_in,
    input  wire logic       isr_enter_ch1_in,
    output logic            overflow_flag_ch0_out,
    output logic            overflow_flag_ch1_out
);
    import dtc_pkg::*;

    logic       rst_meta_n;
    logic       rst_n;
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // Pin synchronisers: three stages, change accepted when last two agree
    logic [3:0] pin_raw;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_val;
    logic [3:0] next_pin_val;
    assign pin_raw = {ext_gate_pin_ch1_in, ext_gate_pin_ch0_in,
                      count_input_ch1_in, count_input_ch0_in};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            always_comb begin
                next_pin_val[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s3[gi] : pin_val[gi];
            end
        end
    endgenerate
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1  <= 4'h0;
            pin_s2  <= 4'h0;
            pin_s3  <= 4'h0;
            pin_val <= 4'h0;
        end else begin
            pin_s1  <= pin_raw;
            pin_s2  <= pin_s1;
            pin_s3  <= pin_s2;
            pin_val <= next_pin_val;
        end
    end

    // Machine-cycle divider and count-input edge detect
    logic [2:0] div_cnt;
    logic [2:0] next_div_cnt;
    logic       tick;
    logic [1:0] cin_prev;
    logic [1:0] next_cin_prev;
    logic [1:0] cin_fall;
    assign tick = (div_cnt == DTC_DIV_LAST);
    always_comb begin
        next_div_cnt  = tick ? 3'h0 : div_cnt + 3'h1;
        next_cin_prev = tick ? pin_val[1:0] : cin_prev;
        cin_fall      = tick ? (cin_prev & ~pin_val[1:0]) : 2'b00;
    end

    // Registers
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] cnt_lo [2];
    logic [7:0] cnt_hi [2];
    logic [7:0] next_ctrl;
    logic [7:0] next_mode;
    logic [7:0] next_lo [2];
    logic [7:0] next_hi [2];
    logic [7:0] next_rdata;

    logic [1:0] gate_en;
    logic [1:0] src_ext;
    logic [1:0] run_bit;
    logic [1:0] gate_pin;
    logic [1:0] ch_run;
    logic [1:0] ch_inc;
    logic [1:0] ch_ovf;
    logic       hi0_inc;
    logic       hi0_ovf;
    dtc_mode_e  ch_mode [2];
    logic [7:0] cnt_next_lo [2];
    logic [7:0] cnt_next_hi [2];

    always_comb begin
        ch_mode[0] = dtc_mode_e'({mode[DTC_MODE_HI], mode[DTC_MODE_LO]});
        ch_mode[1] = dtc_mode_e'({mode[DTC_MODE_HI + DTC_CH1_SHIFT],
                                  mode[DTC_MODE_LO + DTC_CH1_SHIFT]});
        gate_en    = {mode[DTC_MODE_GATE + DTC_CH1_SHIFT], mode[DTC_MODE_GATE]};
        src_ext    = {mode[DTC_MODE_SRC + DTC_CH1_SHIFT], mode[DTC_MODE_SRC]};
        run_bit    = {ctrl[DTC_CTRL_RUN1], ctrl[DTC_CTRL_RUN0]};
        gate_pin   = pin_val[3:2];
        // Channel 0 always needs its run bit; channel 1 does not while channel 0 is in split mode
        ch_run[0]  = run_bit[0] & (~gate_en[0] | gate_pin[0]);
        // Channel 1 runs on its own in split mode of channel 0, halts in mode 3
        ch_run[1]  = ((ch_mode[0] == DTC_MODE_SPLIT) | run_bit[1])
                     & (~gate_en[1] | gate_pin[1])
                     & (ch_mode[1] != DTC_MODE_SPLIT);
        // Split high timer counts machine cycles on channel 1 run bit
        hi0_inc = (ch_mode[0] == DTC_MODE_SPLIT) & run_bit[1] & tick;
        hi0_ovf = hi0_inc & (cnt_hi[0] == 8'hFF);
    end

    // Per-channel count step; register writes override it below
    genvar ci;
    generate
        for (ci = 0; ci < 2; ci++) begin : g_ch
            always_comb begin
                ch_inc[ci] = ch_run[ci] & (src_ext[ci] ? cin_fall[ci] : tick);
            end
            always_comb begin
                cnt_next_lo[ci] = cnt_lo[ci];
                cnt_next_hi[ci] = cnt_hi[ci];
                ch_ovf[ci]      = 1'b0;
                if (ch_inc[ci]) begin
                    case (ch_mode[ci])
                        DTC_MODE_13BIT: begin
                            // Upper three low-byte bits are carried along untouched
                            cnt_next_lo[ci] = {cnt_lo[ci][7:5],
                                               cnt_lo[ci][4:0] + 5'h01};
                            if (cnt_lo[ci][4:0] == DTC_PRESCALE_MAX) begin
                                cnt_next_hi[ci] = cnt_hi[ci] + 8'h01;
                                ch_ovf[ci]      = (cnt_hi[ci] == 8'hFF);
                            end
                        end
                        DTC_MODE_16BIT: begin
                            {cnt_next_hi[ci], cnt_next_lo[ci]} =
                                {cnt_hi[ci], cnt_lo[ci]} + 16'h0001;
                            ch_ovf[ci] = ({cnt_hi[ci], cnt_lo[ci]} == 16'hFFFF);
                        end
                        DTC_MODE_RELOAD: begin
                            // High byte only feeds the reload, never changes here
                            if (cnt_lo[ci] == 8'hFF) begin
                                cnt_next_lo[ci] = cnt_hi[ci];
                                ch_ovf[ci]      = 1'b1;
                            end else begin
                                cnt_next_lo[ci] = cnt_lo[ci] + 8'h01;
                            end
                        end
                        DTC_MODE_SPLIT: begin
                            // Only channel 0 reaches here; channel 1 is gated off
                            cnt_next_lo[ci] = cnt_lo[ci] + 8'h01;
                            ch_ovf[ci]      = (cnt_lo[ci] == 8'hFF);
                        end
                        default: begin
                            cnt_next_lo[ci] = cnt_lo[ci];
                        end
                    endcase
                end
            end
        end
    endgenerate

    always_comb begin
        next_lo[0] = cnt_next_lo[0];
        next_lo[1] = cnt_next_lo[1];
        next_hi[0] = cnt_next_hi[0];
        next_hi[1] = cnt_next_hi[1];
        // Split high byte is its own timer on channel 0's high register
        if (hi0_inc) begin
            next_hi[0] = cnt_hi[0] + 8'h01;
        end

        next_ctrl = ctrl;
        next_mode = mode;
        if (reg_wr_in) begin
            case (reg_addr_in)
                DTC_ADDR_CTRL:  next_ctrl = reg_wdata_in;
                DTC_ADDR_MODE:  next_mode = reg_wdata_in;
                DTC_ADDR_LOW0:  next_lo[0] = reg_wdata_in;
                DTC_ADDR_LOW1:  next_lo[1] = reg_wdata_in;
                DTC_ADDR_HIGH0: next_hi[0] = reg_wdata_in;
                DTC_ADDR_HIGH1: next_hi[1] = reg_wdata_in;
                default: begin
                    next_ctrl = ctrl;
                end
            endcase
        end
        if (isr_enter_ch0_in) begin
            next_ctrl[DTC_CTRL_OVF0] = 1'b0;
        end
        if (isr_enter_ch1_in) begin
            next_ctrl[DTC_CTRL_OVF1] = 1'b0;
        end
        // Hardware set wins over any clear in the same cycle
        if (ch_ovf[0]) begin
            next_ctrl[DTC_CTRL_OVF0] = 1'b1;
        end
        if ((ch_mode[0] == DTC_MODE_SPLIT) ? hi0_ovf : ch_ovf[1]) begin
            next_ctrl[DTC_CTRL_OVF1] = 1'b1;
        end

        next_rdata = 8'h00;
        if (reg_rd_in) begin
            case (reg_addr_in)
                DTC_ADDR_CTRL:  next_rdata = ctrl;
                DTC_ADDR_MODE:  next_rdata = mode;
                DTC_ADDR_LOW0:  next_rdata = cnt_lo[0];
                DTC_ADDR_LOW1:  next_rdata = cnt_lo[1];
                DTC_ADDR_HIGH0: next_rdata = cnt_hi[0];
                DTC_ADDR_HIGH1: next_rdata = cnt_hi[1];
                default:        next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt       <= 3'h0;
            cin_prev      <= 2'b00;
            ctrl          <= DTC_CTRL_RESET;
            mode          <= DTC_MODE_RESET;
            cnt_lo[0]     <= DTC_COUNT_RESET;
            cnt_lo[1]     <= DTC_COUNT_RESET;
            cnt_hi[0]     <= DTC_COUNT_RESET;
            cnt_hi[1]     <= DTC_COUNT_RESET;
            reg_rdata_out <= 8'h00;
        end else begin
            div_cnt       <= next_div_cnt;
            cin_prev      <= next_cin_prev;
            ctrl          <= next_ctrl;
            mode          <= next_mode;
            cnt_lo[0]     <= next_lo[0];
            cnt_lo[1]     <= next_lo[1];
            cnt_hi[0]     <= next_hi[0];
            cnt_hi[1]     <= next_hi[1];
            reg_rdata_out <= next_rdata;
        end
    end

    assign overflow_flag_ch0_out = ctrl[DTC_CTRL_OVF0];
    assign overflow_flag_ch1_out = ctrl[DTC_CTRL_OVF1];
endmodule

// file: dv/dtc_chk.sv
`timescale 1ns/100ps
module dtc_chk
    import dtc_pkg::*;
(
    input wire logic       core_clk_in,
    input wire logic       arst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       isr_enter_ch0_in,
    input wire logic       isr_enter_ch1_in,
    input wire logic       overflow_flag_ch0_out,
    input wire logic       overflow_flag_ch1_out
);
    logic [7:0] mode;
    logic [7:0] next_mode;
    wire logic  cwr = reg_wr_in && reg_addr_in == DTC_ADDR_CTRL;
    wire logic  crd = reg_rd_in && reg_addr_in == DTC_ADDR_CTRL;
    always_comb next_mode = (reg_wr_in && reg_addr_in == DTC_ADDR_MODE) ? reg_wdata_in : mode;
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode <= DTC_MODE_RESET;
        end else begin
            mode <= next_mode;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    property p_idle; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_unmap; reg_rd_in && reg_addr_in > DTC_ADDR_HIGH1 |=> reg_rdata_out == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_mode; reg_rd_in && reg_addr_in == DTC_ADDR_MODE |=> reg_rdata_out == $past(mode);
    endproperty
    a_mode: assert property (p_mode) else $error("mode readback wrong");
    property p_flags; crd |=> reg_rdata_out[7] == $past(overflow_flag_ch1_out)
        && reg_rdata_out[5] == $past(overflow_flag_ch0_out); endproperty
    a_flags: assert property (p_flags) else $error("flag readback wrong");
    property p_set0; cwr && reg_wdata_in[5] && !isr_enter_ch0_in |=> overflow_flag_ch0_out;
    endproperty
    a_set0: assert property (p_set0) else $error("flag 0 not set by write");
    property p_set1; cwr && reg_wdata_in[7] && !isr_enter_ch1_in |=> overflow_flag_ch1_out;
    endproperty
    a_set1: assert property (p_set1) else $error("flag 1 not set by write");
    property p_fall0; $fell(overflow_flag_ch0_out) |-> $past(isr_enter_ch0_in) || $past(cwr);
    endproperty
    a_fall0: assert property (p_fall0) else $error("flag 0 dropped alone");
    property p_fall1; $fell(overflow_flag_ch1_out) |-> $past(isr_enter_ch1_in) || $past(cwr);
    endproperty
    a_fall1: assert property (p_fall1) else $error("flag 1 dropped alone");
endmodule
bind dtc_top dtc_chk i_dtc_chk (.core_clk_in, .arst_n_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .isr_enter_ch0_in, .isr_enter_ch1_in,
    .overflow_flag_ch0_out, .overflow_flag_ch1_out);

// file: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
    import dtc_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       we = 1'b0;
    logic       re = 1'b0;
    logic [7:0] ad = 8'h00;
    logic [7:0] wd = 8'h00;
    logic [7:0] a;
    logic [7:0] b;
    logic [1:0] cin = 2'b00;
    logic [1:0] gt = 2'b00;
    logic [1:0] isr = 2'b00;
    wire  [7:0] rdat;
    wire  [1:0] fl;
    int         error_cnt = 0;
    int         compares = 0;
    always #25 clk = ~clk;
    dtc_top i_dtc_top (.core_clk_in(clk), .arst_n_in(rst_n), .reg_addr_in(ad),
        .reg_wdata_in(wd), .reg_wr_in(we), .reg_rd_in(re), .reg_rdata_out(rdat),
        .count_input_ch0_in(cin[0]), .count_input_ch1_in(cin[1]),
        .ext_gate_pin_ch0_in(gt[0]), .ext_gate_pin_ch1_in(gt[1]),
        .isr_enter_ch0_in(isr[0]), .isr_enter_ch1_in(isr[1]),
        .overflow_flag_ch0_out(fl[0]), .overflow_flag_ch1_out(fl[1]));
    task automatic test_done();
        if (error_cnt == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic wreg(input logic [7:0] x, input logic [7:0] d);
        @(posedge clk);
        ad <= x;
        wd <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] x, output logic [7:0] d);
        @(posedge clk);
        ad <= x;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 d = rdat;
    endtask
    // Read edges 60 clocks apart, so the tick phase never matters
    task automatic meas(input int c, input logic [7:0] e);
        rreg(DTC_ADDR_LOW0 + 8'(c), a);
        repeat (58) @(posedge clk);
        rreg(DTC_ADDR_LOW0 + 8'(c), b);
        chk("count step", e, b - a);
        @(posedge clk);
    endtask
    task automatic wflag(input int c);
        int i;
        for (i = 0; i < 40 && fl[c] !== 1'b1; i++) @(negedge clk);
        if (i == 40) begin
            error_cnt++;
            test_done();
        end
    endtask
    task automatic ovf(input int c, input logic [7:0] m, h, l, el, eh);
        wreg(DTC_ADDR_MODE, 8'(m << (4 * c)));
        wreg(DTC_ADDR_HIGH0 + 8'(c), h);
        wreg(DTC_ADDR_LOW0 + 8'(c), l);
        wreg(DTC_ADDR_CTRL, c ? 8'h40 : 8'h10);
        wflag(c);
        wreg(DTC_ADDR_CTRL, c ? 8'h80 : 8'h20);
        rreg(DTC_ADDR_LOW0 + 8'(c), a);
        chk("low byte", el, a);
        rreg(DTC_ADDR_HIGH0 + 8'(c), a);
        chk("high byte", eh, a);
        wreg(DTC_ADDR_CTRL, 8'h00);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int r = 0; r < 6; r++) begin
            rreg(DTC_ADDR_CTRL + 8'(r), a);
            chk("reset value", 8'h00, a);
        end
        wreg(8'h90, 8'hFF);
        rreg(8'h90, a);
        chk("unmapped", 8'h00, a);
        wreg(DTC_ADDR_MODE, 8'hA5);
        rreg(DTC_ADDR_MODE, a);
        chk("mode", 8'hA5, a);
        wreg(DTC_ADDR_CTRL, 8'hA0);
        rreg(DTC_ADDR_CTRL, a);
        chk("ctrl", 8'hA0, a);
        for (int c = 0; c < 2; c++) begin
            @(posedge clk);
            isr <= 2'(1 << c);
            @(posedge clk);
            isr <= 2'b00;
            @(negedge clk);
            chk("flags", c ? 8'h00 : 8'h02, 8'(fl));
        end
        for (int c = 0; c < 2; c++) begin
            ovf(c, 8'h00, 8'hFF, 8'hFF, 8'hE0, 8'h00);
            ovf(c, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00);
            ovf(c, 8'h02, 8'hA0, 8'hFF, 8'hA0, 8'hA0);
        end
        wreg(DTC_ADDR_MODE, 8'h33);
        wreg(DTC_ADDR_LOW1, 8'h5A);
        wreg(DTC_ADDR_HIGH0, 8'hFE);
        wreg(DTC_ADDR_LOW0, 8'hFE);
        wreg(DTC_ADDR_CTRL, 8'h50);
        wflag(1);
        wreg(DTC_ADDR_CTRL, 8'hA0);
        chk("split flags", 8'h03, 8'(fl));
        rreg(DTC_ADDR_HIGH0, a);
        chk("split high", 8'h00, a);
        rreg(DTC_ADDR_LOW0, a);
        chk("split low", 8'h00, a);
        rreg(DTC_ADDR_LOW1, a);
        chk("halted low", 8'h5A, a);
        for (int c = 0; c < 2; c++) begin
            wreg(DTC_ADDR_MODE, 8'(8'h05 << (4 * c)));
            wreg(DTC_ADDR_LOW0 + 8'(c), 8'h00);
            wreg(DTC_ADDR_CTRL, c ? 8'h40 : 8'h10);
            repeat (3) begin
                @(posedge clk);
                cin[c] <= 1'b1;
                repeat (20) @(posedge clk);
                cin[c] <= 1'b0;
                repeat (20) @(posedge clk);
            end
            repeat (10) @(posedge clk);
            rreg(DTC_ADDR_LOW0 + 8'(c), a);
            chk("edge count", 8'h03, a);
            wreg(DTC_ADDR_MODE, 8'(8'h01 << (4 * c)));
            meas(c, 8'(60 / DTC_TIMER_DIV));
            wreg(DTC_ADDR_MODE, 8'(8'h09 << (4 * c)));
            meas(c, 8'h00);
            gt[c] <= 1'b1;
            repeat (10) @(posedge clk);
            meas(c, 8'(60 / DTC_TIMER_DIV));
            wreg(DTC_ADDR_CTRL, 8'h00);
            meas(c, 8'h00);
            gt <= 2'b00;
        end
        test_done();
    end
endmodule
